// ===== src/cpar_map.svh
`ifndef CPAR_MAP_SVH
`define CPAR_MAP_SVH
`define CPAR_IDX_PLL_FRACTION 5'h1c
`define CPAR_IDX_AUDIO_CTL4 5'h1d
`define CPAR_IDX_HANDSET_GAIN 5'h1e
`define CPAR_IDX_PLL_ENABLE 5'h1b
`define CPAR_IDX_STATUS 5'h10
`define CPAR_FRAC_MAX 14'h270f
`define CPAR_CTL4_RST 16'h0000
`define CPAR_HGAIN_RST 16'hff00
`define CPAR_GAIN_MAX 7'h7f
`define CPAR_FSREF_HZ 48000
`define CPAR_CLK_HZ 10000000
`define CPAR_TICK_CYC (`CPAR_CLK_HZ / `CPAR_FSREF_HZ)
`endif

// ===== src/cpar_pkg.sv
package cpar_pkg;
  typedef struct packed {
    logic mic_gain_step_disable;
    logic dac_gain_step_disable;
    logic sidetone_step_disable;
    logic cellphone_step_disable;
    logic buzzer_step_disable;
    logic [1:0] agc_hysteresis_sel;
    logic [1:0] headset_bias_sel;
    logic handset_bias_sel;
  } cpar_ctl4_s;
  typedef enum logic [1:0] {
    CPAR_BIAS_HIGH,
    CPAR_BIAS_MID,
    CPAR_BIAS_LOW
  } cpar_bias_e;
endpackage : cpar_pkg

// ===== src/cpar_regs.sv
// Functional notes
// (RQ1) Fractional multiplier field bits 15:2 above 9999 is used as 9999.
// (RQ2) Fractional value is applied only while the multiplier is enabled.
// (RQ3) Multiplier enable bit: 0 disables, 1 enables and gates fraction.
// (RQ4) Software writes zero to fraction low bits; they read zero.
// (RQ5) Bit 15 clear soft-steps mic gain, set changes it at once.
// (RQ6) Bit 14 clear soft-steps DAC gain, set disables stepping.
// (RQ7) Bit 13 sidetone stepping moves 0.5 dB per sample tick.
// (RQ8) Bit 12 cell-phone stepping moves 0.5 dB per sample tick.
// (RQ9) Bit 11 buzzer stepping moves 3 dB per sample tick.
// (RQ10) Hysteresis codes give 1, 2, 4 dB or none; handset AGC only.
// (RQ11) Headset bias: 00 high, 01 middle, 10 and 11 lowest.
// (RQ12) Handset bias bit: 0 higher level, 1 lower level.
// (RQ13) Software writes zero to bits 5:2 of audio control four.
// (RQ14) Short flag reads 1 once a headphone short is seen.
// (RQ15) Handset mute bit mutes when 1 and resets to 1.
// (RQ16) Handset gain 0 to 59.5 dB in half-dB steps, reset all ones.
// (RQ17) With AGC on, mute and gain read back the applied AGC gain; the code does so only while handset_selected is 1.
// (RQ18) Three-bit AGC target code is passed to the AGC.
// (RQ19) Four-bit AGC timing code selects attack and decay pair.
// (RQ20) AGC enable hands the gain stage to the AGC when 1.
// (RQ21) Stepping moves one increment per tick toward target, then stops.
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cpar_map.svh"
module cpar_regs
  import cpar_pkg::*;
#(
  parameter int TICK_CYC = `CPAR_TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic headphone_short_in,
  input wire logic handset_selected,
  input wire logic [7:0] agc_applied_gain,
  output logic multiplier_enable,
  output logic [13:0] pll_fraction_value,
  output cpar_ctl4_s ctl4,
  output cpar_bias_e headset_bias_level,
  output logic handset_bias_level,
  output logic [2:0] agc_hyst_db,
  output logic agc_hyst_active,
  output logic handset_input_mute,
  output logic [6:0] handset_applied_gain,
  output logic [2:0] handset_agc_target,
  output logic [3:0] handset_agc_timing,
  output logic handset_agc_enable,
  output logic fsref_tick
);

  // ****************************************
  // Bus handshake
  // ****************************************
  // One wait cycle per access: answer lands on the second edge.
  logic ack_r;
  logic [13:0] frac_r;
  logic en_r;
  cpar_ctl4_s ctl4_r;
  logic short_r;
  logic mute_r;
  logic [6:0] gain_r;
  logic [2:0] tgt_r;
  logic [3:0] tc_r;
  logic agc_en_r;
  logic [6:0] app_r;
  logic [1:0] sh_sync_r;
  logic [15:0] rd_nxt;
  logic wr_go;
  logic req;

  if (TICK_CYC < 1 || TICK_CYC > 65536) begin : g_bad_tick
    $error("TICK_CYC must lie between 1 and 65536");
  end

  assign req = (avs_read | avs_write) & ~ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_go = avs_write & ack_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  function automatic logic [13:0] clamp_frac(input logic [13:0] v);
    clamp_frac = (v > `CPAR_FRAC_MAX) ? `CPAR_FRAC_MAX : v; // RQ1
  endfunction : clamp_frac

  // ****************************************
  // Register storage
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_r <= 14'h0000;
      en_r <= 1'b0;
    end else if (wr_go && avs_address == `CPAR_IDX_PLL_FRACTION) begin
      frac_r <= clamp_frac(avs_writedata[15:2]); // RQ1
    end else if (wr_go && avs_address == `CPAR_IDX_PLL_ENABLE) begin
      en_r <= avs_writedata[15]; // RQ3
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl4_r <= cpar_ctl4_s'(10'h000);
    end else if (wr_go && avs_address == `CPAR_IDX_AUDIO_CTL4) begin
      ctl4_r <= cpar_ctl4_s'(avs_writedata[15:6]);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mute_r <= 1'b1; // RQ15
      gain_r <= `CPAR_GAIN_MAX; // RQ16
      tgt_r <= 3'h0;
      tc_r <= 4'h0;
      agc_en_r <= 1'b0;
    end else if (wr_go && avs_address == `CPAR_IDX_HANDSET_GAIN) begin
      mute_r <= avs_writedata[15];
      gain_r <= avs_writedata[14:8];
      tgt_r <= avs_writedata[7:5]; // RQ18
      tc_r <= avs_writedata[4:1]; // RQ19
      agc_en_r <= avs_writedata[0];
    end
  end

  // ****************************************
  // Short flag
  // ****************************************
  // Sticky until reset so a fault held across a clock edge is never missed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_sync_r <= 2'b00;
      short_r <= 1'b0;
    end else begin
      sh_sync_r <= {sh_sync_r[0], headphone_short_in};
      if (sh_sync_r[1]) begin
        short_r <= 1'b1; // RQ14
      end
    end
  end

  // ****************************************
  // Sample-rate tick and stepping
  // ****************************************
  logic [15:0] tick_cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 16'h0000;
      fsref_tick <= 1'b0;
    end else if (tick_cnt_r == 16'(TICK_CYC - 1)) begin
      tick_cnt_r <= 16'h0000;
      fsref_tick <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      fsref_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      app_r <= `CPAR_GAIN_MAX;
    end else if (ctl4_r.mic_gain_step_disable) begin
      app_r <= gain_r; // RQ5
    end else if (fsref_tick && app_r < gain_r) begin
      app_r <= app_r + 7'h01; // RQ21
    end else if (fsref_tick && app_r > gain_r) begin
      app_r <= app_r - 7'h01; // RQ21
    end
  end

  // ****************************************
  // Outputs and readback
  // ****************************************
  always_comb begin
    rd_nxt = 16'h0000;
    if (avs_address == `CPAR_IDX_PLL_FRACTION) begin
      rd_nxt = {frac_r, 2'b00}; // RQ4
    end else if (avs_address == `CPAR_IDX_PLL_ENABLE) begin
      rd_nxt = {en_r, 15'h0000};
    end else if (avs_address == `CPAR_IDX_AUDIO_CTL4) begin
      rd_nxt = {ctl4_r, 4'h0, short_r, 1'b0}; // RQ13 RQ14
    end else if (avs_address == `CPAR_IDX_HANDSET_GAIN) begin
      if (agc_en_r && handset_selected) begin
        rd_nxt = {agc_applied_gain, tgt_r, tc_r, agc_en_r}; // RQ17
      end else begin
        rd_nxt = {mute_r, gain_r, tgt_r, tc_r, agc_en_r};
      end
    end else if (avs_address == `CPAR_IDX_STATUS) begin
      rd_nxt = {15'h0000, app_r == gain_r};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req) begin
      avs_readdata <= {16'h0000, rd_nxt};
    end
  end

  assign multiplier_enable = en_r; // RQ3
  assign pll_fraction_value = en_r ? frac_r : 14'h0000; // RQ2
  assign ctl4 = ctl4_r; // RQ6 RQ7 RQ8 RQ9
  always_comb begin
    if (ctl4_r.headset_bias_sel == 2'b00) begin
      headset_bias_level = CPAR_BIAS_HIGH; // RQ11
    end else if (ctl4_r.headset_bias_sel == 2'b01) begin
      headset_bias_level = CPAR_BIAS_MID;
    end else begin
      headset_bias_level = CPAR_BIAS_LOW;
    end
  end
  assign handset_bias_level = ~ctl4_r.handset_bias_sel; // RQ12
  assign agc_hyst_db = (ctl4_r.agc_hysteresis_sel == 2'b11) ? 3'd0 :
    (3'd1 << ctl4_r.agc_hysteresis_sel); // RQ10
  assign agc_hyst_active = agc_en_r & handset_selected; // RQ10
  assign handset_input_mute = agc_en_r ? 1'b0 : mute_r; // RQ15 RQ20
  assign handset_applied_gain = app_r; // RQ16
  assign handset_agc_target = tgt_r;
  assign handset_agc_timing = tc_r;
  assign handset_agc_enable = agc_en_r; // RQ20

  // ****************************************
  // Checks
  // ****************************************
  property p_clamp;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && avs_address == `CPAR_IDX_PLL_FRACTION) |=>
        frac_r <= `CPAR_FRAC_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("fraction over max"); // RQ1
  property p_gate;
    @(posedge clk) disable iff (!rst_n)
      !multiplier_enable |-> pll_fraction_value == 14'h0000;
  endproperty
  a_gate: assert property (p_gate) else $error("fraction leaks"); // RQ2
  property p_wait;
    @(posedge clk) disable iff (!rst_n)
      $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bad wait timing");
  property p_short;
    @(posedge clk) disable iff (!rst_n)
      sh_sync_r[1] |=> short_r;
  endproperty
  a_short: assert property (p_short) else $error("short lost"); // RQ14
  property p_nodis;
    @(posedge clk) disable iff (!rst_n)
      ctl4_r.mic_gain_step_disable |=> app_r == $past(gain_r);
  endproperty
  a_nodis: assert property (p_nodis) else $error("no instant gain"); // RQ5
  property p_step;
    @(posedge clk) disable iff (!rst_n)
      (!fsref_tick && !ctl4_r.mic_gain_step_disable) |=> $stable(app_r);
  endproperty
  a_step: assert property (p_step) else $error("step off tick"); // RQ21
  property p_bias;
    @(posedge clk) disable iff (!rst_n)
      ctl4_r.headset_bias_sel[1] |-> headset_bias_level == CPAR_BIAS_LOW;
  endproperty
  a_bias: assert property (p_bias) else $error("bias level"); // RQ11
  property p_agc;
    @(posedge clk) disable iff (!rst_n)
      agc_en_r |-> !handset_input_mute;
  endproperty
  a_agc: assert property (p_agc) else $error("mute under agc"); // RQ20
  property p_frac_rd;
    @(posedge clk) disable iff (!rst_n)
      (req && avs_address == `CPAR_IDX_PLL_FRACTION) |=>
        avs_readdata[1:0] == 2'b00;
  endproperty
  a_frac_rd: assert property (p_frac_rd) else $error("low bits set"); // RQ4
  property p_en_wr;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && avs_address == `CPAR_IDX_PLL_ENABLE) |=>
        multiplier_enable == $past(avs_writedata[15]);
  endproperty
  a_en_wr: assert property (p_en_wr) else $error("enable lost"); // RQ3
  property p_dac_wr;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && avs_address == `CPAR_IDX_AUDIO_CTL4) |=>
        ctl4.dac_gain_step_disable == $past(avs_writedata[14]);
  endproperty
  a_dac_wr: assert property (p_dac_wr) else $error("step bit"); // RQ6
  property p_side_wr;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && avs_address == `CPAR_IDX_AUDIO_CTL4) |=>
        ctl4.sidetone_step_disable == $past(avs_writedata[13]);
  endproperty
  a_side_wr: assert property (p_side_wr) else $error("step bit"); // RQ7
  property p_cell_wr;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && avs_address == `CPAR_IDX_AUDIO_CTL4) |=>
        ctl4.cellphone_step_disable == $past(avs_writedata[12]);
  endproperty
  a_cell_wr: assert property (p_cell_wr) else $error("step bit"); // RQ8
  property p_buzz_wr;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && avs_address == `CPAR_IDX_AUDIO_CTL4) |=>
        ctl4.buzzer_step_disable == $past(avs_writedata[11]);
  endproperty
  a_buzz_wr: assert property (p_buzz_wr) else $error("step bit"); // RQ9
  property p_hyst;
    @(posedge clk) disable iff (!rst_n)
      ctl4_r.agc_hysteresis_sel == 2'b11 |-> agc_hyst_db == 3'd0;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis"); // RQ10
  property p_mid;
    @(posedge clk) disable iff (!rst_n)
      ctl4_r.headset_bias_sel == 2'b01 |-> headset_bias_level == CPAR_BIAS_MID;
  endproperty
  a_mid: assert property (p_mid) else $error("middle bias"); // RQ11
  property p_hbias;
    @(posedge clk) disable iff (!rst_n)
      ctl4_r.handset_bias_sel |-> !handset_bias_level;
  endproperty
  a_hbias: assert property (p_hbias) else $error("handset bias"); // RQ12
  property p_sticky;
    @(posedge clk) disable iff (!rst_n)
      short_r |=> short_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("short cleared"); // RQ14
  property p_mute_wr;
    @(posedge clk) disable iff (!rst_n)
      (wr_go && avs_address == `CPAR_IDX_HANDSET_GAIN) |=>
        mute_r == $past(avs_writedata[15]);
  endproperty
  a_mute_wr: assert property (p_mute_wr) else $error("mute lost"); // RQ15
  property p_agc_rd;
    @(posedge clk) disable iff (!rst_n)
      (req && avs_address == `CPAR_IDX_HANDSET_GAIN &&
        agc_en_r && handset_selected) |=>
        avs_readdata[15:8] == $past(agc_applied_gain);
  endproperty
  a_agc_rd: assert property (p_agc_rd) else $error("agc gain not read"); // RQ17
  property p_stop;
    @(posedge clk) disable iff (!rst_n)
      (app_r == gain_r && !ctl4_r.mic_gain_step_disable) |=> $stable(app_r);
  endproperty
  a_stop: assert property (p_stop) else $error("step past target"); // RQ21
  property p_tick;
    @(posedge clk) disable iff (!rst_n)
      (fsref_tick && TICK_CYC > 1) |=> !fsref_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long"); // RQ21
endmodule : cpar_regs
`default_nettype wire

// ===== dv/tb_cpar_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpar_map.svh"
module tb_cpar_regs
  import cpar_pkg::*;
;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  localparam int TCYC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic headphone_short_in = 1'b0;
  logic handset_selected = 1'b0;
  logic [7:0] agc_applied_gain = 8'h00;
  logic multiplier_enable, handset_bias_level, agc_hyst_active;
  logic [13:0] pll_fraction_value;
  cpar_ctl4_s ctl4;
  cpar_bias_e headset_bias_level;
  logic [2:0] agc_hyst_db, handset_agc_target;
  logic handset_input_mute, handset_agc_enable, fsref_tick;
  logic [6:0] handset_applied_gain;
  logic [3:0] handset_agc_timing;
  logic [31:0] rd;
  int num_errors = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  cpar_regs #(.TICK_CYC(TCYC)) i_dut (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .headphone_short_in(headphone_short_in),
    .handset_selected(handset_selected),
    .agc_applied_gain(agc_applied_gain),
    .multiplier_enable(multiplier_enable),
    .pll_fraction_value(pll_fraction_value), .ctl4(ctl4),
    .headset_bias_level(headset_bias_level),
    .handset_bias_level(handset_bias_level),
    .agc_hyst_db(agc_hyst_db), .agc_hyst_active(agc_hyst_active),
    .handset_input_mute(handset_input_mute),
    .handset_applied_gain(handset_applied_gain),
    .handset_agc_target(handset_agc_target),
    .handset_agc_timing(handset_agc_timing),
    .handset_agc_enable(handset_agc_enable), .fsref_tick(fsref_tick)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // The request stays up until waitrequest is seen low at an edge or 20 edges pass.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) chk("bus answer", 32'h0000_0001, 32'h0000_0000);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    bus(1'b0, `CPAR_IDX_PLL_FRACTION, 16'h0000, rd);
    chk("fraction reset", rd, 32'h0000_0000);
    bus(1'b0, `CPAR_IDX_HANDSET_GAIN, 16'h0000, rd);
    chk("handset reset", rd, 32'h0000_ff00);
    chk("applied reset", {25'h0, handset_applied_gain}, 32'h0000_007f);
    chk("mute reset", {31'h0, handset_input_mute}, 32'h0000_0001);
    bus(1'b0, `CPAR_IDX_AUDIO_CTL4, 16'h0000, rd);
    chk("ctl4 reset", rd, 32'h0000_0000);
    bus(1'b0, 5'h05, 16'h0000, rd);
    chk("unmapped read", rd, 32'h0000_0000);
  endtask : t_reset

  task automatic t_fraction;
    wr(`CPAR_IDX_PLL_FRACTION, 16'h9c40);
    repeat (2) @(posedge clk);
    chk("fraction off", {18'h0, pll_fraction_value}, 32'h0000_0000);
    wr(`CPAR_IDX_PLL_ENABLE, 16'h8000);
    repeat (2) @(posedge clk);
    chk("enable", {31'h0, multiplier_enable}, 32'h0000_0001);
    chk("fraction clamp", {18'h0, pll_fraction_value}, 32'h0000_270f);
    wr(`CPAR_IDX_PLL_FRACTION, 16'h1348);
    bus(1'b0, `CPAR_IDX_PLL_FRACTION, 16'h0000, rd);
    chk("fraction low bits", rd & 32'h0000_0003, 32'h0000_0000);
    chk("fraction", {18'h0, pll_fraction_value}, 32'h0000_04d2);
  endtask : t_fraction

  task automatic t_ctl4;
    logic [4:0] stp;
    logic [1:0] c;
    logic [2:0] hy [4] = '{3'd1, 3'd2, 3'd4, 3'd0};
    cpar_bias_e bl [4] = '{CPAR_BIAS_HIGH, CPAR_BIAS_MID, CPAR_BIAS_LOW,
                           CPAR_BIAS_LOW};
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      stp = c[0] ? 5'h15 : 5'h0a;
      wr(`CPAR_IDX_AUDIO_CTL4, {stp, c, c, c[0], 6'h00});
      bus(1'b0, `CPAR_IDX_AUDIO_CTL4, 16'h0000, rd);
      chk("ctl4 read", {17'h0, rd[15:1]}, {17'h0, stp, c, c, c[0], 5'h00});
      chk("ctl4 out", {22'h0, ctl4}, {22'h0, stp, c, c, c[0]});
      chk("dac", {31'h0, ctl4.dac_gain_step_disable}, {31'h0, stp[3]});
      chk("st", {31'h0, ctl4.sidetone_step_disable}, {31'h0, stp[2]});
      chk("cp", {31'h0, ctl4.cellphone_step_disable}, {31'h0, stp[1]});
      chk("buzz", {31'h0, ctl4.buzzer_step_disable}, {31'h0, stp[0]});
      chk("hysteresis", {29'h0, agc_hyst_db}, {29'h0, hy[i]});
      chk("headset bias", {30'h0, headset_bias_level}, {30'h0, bl[i]});
      chk("handset bias", {31'h0, handset_bias_level}, {31'h0, ~c[0]});
    end
  endtask : t_ctl4

  task automatic t_short;
    headphone_short_in <= 1'b1;
    repeat (4) @(posedge clk);
    headphone_short_in <= 1'b0;
    repeat (4) @(posedge clk);
    bus(1'b0, `CPAR_IDX_AUDIO_CTL4, 16'h0000, rd);
    chk("short flag", {31'h0, rd[1]}, 32'h0000_0001);
  endtask : t_short

  task automatic t_step;
    int ticks;
    wr(`CPAR_IDX_AUDIO_CTL4, 16'h0000);
    wr(`CPAR_IDX_HANDSET_GAIN, 16'h1000);
    ticks = 0;
    for (int i = 0; i < 800 && handset_applied_gain !== 7'h10; i++) begin
      @(posedge clk);
      if (fsref_tick === 1'b1) ticks++;
    end
    chk("step ticks", {31'h0, ticks >= 109 && ticks <= 112}, 32'h1);
    chk("unmute", {31'h0, handset_input_mute}, 32'h0000_0000);
    bus(1'b0, `CPAR_IDX_STATUS, 16'h0000, rd);
    chk("step done", {31'h0, rd[0]}, 32'h0000_0001);
    wr(`CPAR_IDX_AUDIO_CTL4, 16'h8000);
    wr(`CPAR_IDX_HANDSET_GAIN, 16'h4000);
    repeat (2) @(posedge clk);
    chk("no step", {25'h0, handset_applied_gain}, 32'h0000_0040);
  endtask : t_step

  task automatic t_agc;
    handset_selected <= 1'b1;
    agc_applied_gain <= 8'he8;
    wr(`CPAR_IDX_HANDSET_GAIN, 16'hc0b5);
    repeat (2) @(posedge clk);
    chk("agc target", {29'h0, handset_agc_target}, 32'h0000_0005);
    chk("agc timing", {28'h0, handset_agc_timing}, 32'h0000_000a);
    chk("agc enable", {31'h0, handset_agc_enable}, 32'h0000_0001);
    bus(1'b0, `CPAR_IDX_HANDSET_GAIN, 16'h0000, rd);
    chk("agc gain read", {24'h0, rd[15:8]}, 32'h0000_00e8);
    chk("agc mute", {31'h0, handset_input_mute}, 32'h0000_0000);
    chk("hyst active", {31'h0, agc_hyst_active}, 32'h0000_0001);
    handset_selected <= 1'b0;
    bus(1'b0, `CPAR_IDX_HANDSET_GAIN, 16'h0000, rd);
    chk("agc off read", {24'h0, rd[15:8]}, 32'h0000_00c0);
    chk("hyst idle", {31'h0, agc_hyst_active}, 32'h0000_0000);
  endtask : t_agc

  // ****************************************************************
  // Sequence, watchdog and verdict
  // ****************************************************************
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fraction();
    t_ctl4();
    t_short();
    t_step();
    t_agc();
    wrap_up();
  end

  // The scenarios need about 550 cycles; allow 15000, over twenty-five times that.
  initial begin
    #(100 * 15000);
    num_errors++;
    wrap_up();
  end
endmodule : tb_cpar_regs
`default_nettype wire
